// ### logic/tsi_host_port_output_control.sv
// Host port, frame timing, switching and output control of the slot interchange
`timescale 1ns/1ps

// How it works
// - Port activity is ignored unless chip select is low.
// - Access starts only with strobe and select low; reads drive the data bus.
// - Read/write input high reads, low writes, fixing data bus direction.
// - Sixteen address lines reach connection memory, data memory and registers.
// - Acknowledge pulls low, drives high at cycle end, then releases.
// - Master enable low and standby bit low float every serial output except upper pins carrying enables.
// - Master enable high drives outputs; mode 11 channels still float.
// - Reset clears counters and registers and floats serial outputs and data bus.
// - Serial bit clock at 32.768 MHz times all stream shifting.
// - Frame pulse polarity is learned automatically from the idle level.
// - Bit count from frame pulse to evaluation edge is readable.
// - Any input channel can feed any output channel, 32 by 32 streams.
// - Each output channel picks variable or constant delay.
// - Each input stream has its own bit offset from frame boundary.
// - Mode 11 floats only that output channel's eight bits.
// - 512 channels of eight bits fill each frame between pulses.
// - Upper sixteen pins carry streams 16-31 or enables of streams 0-15.
module tsi_host_port_output_control (
  input wire logic mclk,
  input wire logic reset,
  input wire logic serial_bit_clock,
  input wire logic frame_sync_in,
  input wire logic delay_measure_input,
  input wire logic master_output_enable,
  input wire logic [tsi_pkg::STREAMS-1:0] serial_in_streams,
  output logic [tsi_pkg::STREAMS-1:0] serial_out_streams,
  output logic [tsi_pkg::STREAMS-1:0] serial_out_oe,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic [15:0] host_address,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic transfer_ack,
  output logic transfer_ack_oe
);
  import tsi_pkg::*;

  localparam int SYNC_W = STREAMS + 38;

  // Pin synchronisers
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [2:0] bclk_r;
  logic cs_n_s;
  logic ds_n_s;
  logic rw_s;
  logic [15:0] addr_s;
  logic [15:0] din_s;
  logic ode_s;
  logic fs_s;
  logic fe_s;
  logic [STREAMS-1:0] rx_s;
  logic bit_edge;

  // Frame timing
  logic fs_prev_r;
  logic idle_lvl_r;
  logic fe_prev_r;
  logic frame_start;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BIT_CNT_W-1:0] meas_cnt_r;
  logic [BIT_CNT_W-1:0] meas_r;
  logic bank_r;
  logic [CH_W-1:0] ch_now;
  logic [CH_W-1:0] ch_next;

  // Memories and per-stream state
  logic [7:0] dmem [0:DMEM_WORDS-1];
  logic [15:0] cmem [0:CMEM_WORDS-1];
  logic [DLY_TAPS-1:0] dly_r [0:STREAMS-1];
  logic [7:0] in_sr_r [0:STREAMS-1];
  logic [7:0] out_sr_r [0:STREAMS-1];
  logic [7:0] nxt_byte [0:STREAMS-1];
  logic [STREAMS-1:0] tx_bit_r;
  logic [STREAMS-1:0] out_en_r;
  logic [OFFSET_W-1:0] offs_r [0:STREAMS-1];

  // Host side
  host_state_e hp_r;
  logic [15:0] addr_r;
  logic [15:0] din_r;
  logic rd_r;
  logic standby_r;
  logic oei_sel_r;
  logic drive_on;
  logic wr_go;

  always_ff @(posedge mclk) begin
    meta_r <= {chip_select_n, data_strobe_n, read_write, host_address, host_data_in,
               master_output_enable, frame_sync_in, delay_measure_input,
               serial_in_streams};
    sync_r <= meta_r;
    bclk_r <= {bclk_r[1:0], serial_bit_clock};
  end

  assign {cs_n_s, ds_n_s, rw_s, addr_s, din_s, ode_s, fs_s, fe_s, rx_s} = sync_r;
  assign bit_edge = bclk_r[1] & ~bclk_r[2];

  // Pulse differs from the learned idle level after an idle sample
  assign frame_start = bit_edge & (fs_s != idle_lvl_r) & (fs_prev_r == idle_lvl_r);
  assign ch_now = bit_cnt_r[BIT_CNT_W-1:3];
  assign ch_next = ch_now + 9'h001;
  assign drive_on = ode_s | standby_r;
  assign wr_go = (hp_r == hp_acc) & ~rd_r;

  // Byte fetched for one output slot
  function automatic logic [7:0] src_byte(input logic [SLOT_W-1:0] slot);
    logic [15:0] w;
    w = cmem[slot];
    case (w[MODE_HI:MODE_LO])
      MODE_PROC: src_byte = w[7:0];
      MODE_CONST: src_byte = dmem[{~bank_r, w[SLOT_W-1:0]}];
      default: src_byte = dmem[{bank_r, w[SLOT_W-1:0]}];
    endcase
  endfunction

  // Register and memory read decode
  function automatic logic [15:0] host_read(input logic [15:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a[15:14] == SEL_CMEM) begin
      v = cmem[a[SLOT_W-1:0]];
    end else if (a[15:14] == SEL_DMEM) begin
      v = {8'h00, dmem[{~bank_r, a[SLOT_W-1:0]}]};
    end else if (a == REG_CTRL) begin
      v[CTRL_STANDBY_BIT] = standby_r;
      v[CTRL_OEI_BIT] = oei_sel_r;
    end else if (a == REG_STATUS) begin
      v[STATUS_FMT_BIT] = ~idle_lvl_r;
    end else if (a == REG_DELAY) begin
      v = {4'h0, meas_r};
    end else if (a[15:5] == REG_OFFS_BASE[15:5]) begin
      v = {13'h0000, offs_r[a[STREAM_W-1:0]]};
    end
    return v;
  endfunction

  // Frame pulse format detection
  always_ff @(posedge mclk) begin
    if (reset) begin
      fs_prev_r <= IDLE_LVL_RST;
      idle_lvl_r <= IDLE_LVL_RST;
    end else if (bit_edge) begin
      fs_prev_r <= fs_s;
      if (fs_s == fs_prev_r) begin
        idle_lvl_r <= fs_s;
      end
    end
  end

  // Bit counter and bank swap
  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_cnt_r <= '0;
      bank_r <= 1'b0;
    end else if (frame_start) begin
      bit_cnt_r <= '0;
      bank_r <= ~bank_r;
    end else if (bit_edge) begin
      bit_cnt_r <= bit_cnt_r + 12'h001;
    end
  end

  // Frame offset measurement
  always_ff @(posedge mclk) begin
    if (reset) begin
      meas_cnt_r <= '0;
      meas_r <= '0;
      fe_prev_r <= 1'b0;
    end else begin
      fe_prev_r <= fe_s;
      if (frame_start) begin
        meas_cnt_r <= '0;
      end else if (bit_edge) begin
        meas_cnt_r <= meas_cnt_r + 12'h001;
      end
      if (fe_s && !fe_prev_r) begin
        meas_r <= meas_cnt_r;
      end
    end
  end

  // Input capture into data memory
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int s = 0; s < STREAMS; s++) begin
        dly_r[s] <= '0;
        in_sr_r[s] <= '0;
      end
    end else if (bit_edge) begin
      for (int s = 0; s < STREAMS; s++) begin
        dly_r[s] <= {dly_r[s][DLY_TAPS-2:0], rx_s[s]};
        in_sr_r[s] <= {in_sr_r[s][6:0], dly_r[s][offs_r[s]]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset && bit_edge && bit_cnt_r[2:0] == 3'h7) begin
      for (int s = 0; s < STREAMS; s++) begin
        dmem[{bank_r, STREAM_W'(s), ch_now}] <= {in_sr_r[s][6:0], dly_r[s][offs_r[s]]};
      end
    end
  end

  // Byte each stream sends in the coming channel
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      nxt_byte[s] = src_byte({STREAM_W'(s), ch_next});
    end
  end

  // Output shifting and per-channel enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_bit_r <= '0;
      out_en_r <= '0;
      for (int s = 0; s < STREAMS; s++) begin
        out_sr_r[s] <= '0;
      end
    end else if (bit_edge) begin
      for (int s = 0; s < STREAMS; s++) begin
        if (bit_cnt_r[2:0] == 3'h7) begin
          tx_bit_r[s] <= nxt_byte[s][7];
          out_sr_r[s] <= {nxt_byte[s][6:0], 1'b0};
          out_en_r[s] <= cmem[{STREAM_W'(s), ch_next}][MODE_HI:MODE_LO] != MODE_HIZ;
        end else begin
          tx_bit_r[s] <= out_sr_r[s][7];
          out_sr_r[s] <= {out_sr_r[s][6:0], 1'b0};
        end
      end
    end
  end

  // Output pins and enables
  always_ff @(posedge mclk) begin
    if (reset) begin
      serial_out_streams <= '0;
      serial_out_oe <= '0;
    end else begin
      for (int s = 0; s < STREAMS; s++) begin
        if (oei_sel_r && s >= OEI_FIRST) begin
          serial_out_streams[s] <= out_en_r[s - OEI_FIRST] & drive_on;
          serial_out_oe[s] <= 1'b1;
        end else begin
          serial_out_streams[s] <= tx_bit_r[s];
          serial_out_oe[s] <= out_en_r[s] & drive_on;
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      standby_r <= CTRL_RST;
      oei_sel_r <= CTRL_RST;
      for (int s = 0; s < STREAMS; s++) begin
        offs_r[s] <= OFFS_RST;
      end
    end else if (wr_go) begin
      if (addr_r == REG_CTRL) begin
        standby_r <= din_r[CTRL_STANDBY_BIT];
        oei_sel_r <= din_r[CTRL_OEI_BIT];
      end else if (addr_r[15:5] == REG_OFFS_BASE[15:5]) begin
        offs_r[addr_r[STREAM_W-1:0]] <= din_r[OFFSET_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset && wr_go && addr_r[15:14] == SEL_CMEM) begin
      cmem[addr_r[SLOT_W-1:0]] <= din_r;
    end
  end

  // Host access sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      hp_r <= hp_idle;
      addr_r <= '0;
      din_r <= '0;
      rd_r <= 1'b0;
      host_data_out <= '0;
      host_data_oe <= 1'b0;
      transfer_ack <= 1'b1;
      transfer_ack_oe <= 1'b0;
    end else begin
      case (hp_r)
        hp_idle: begin
          host_data_oe <= 1'b0;
          transfer_ack_oe <= 1'b0;
          if (!cs_n_s && !ds_n_s) begin
            addr_r <= addr_s;
            din_r <= din_s;
            rd_r <= rw_s;
            hp_r <= hp_acc;
          end
        end
        hp_acc: begin
          if (rd_r) begin
            host_data_out <= host_read(addr_r);
          end
          transfer_ack <= 1'b0;
          transfer_ack_oe <= 1'b1;
          hp_r <= hp_ack;
        end
        hp_ack: begin
          host_data_oe <= rd_r & ~cs_n_s & ~ds_n_s;
          if (cs_n_s || ds_n_s) begin
            host_data_oe <= 1'b0;
            transfer_ack <= 1'b1;
            hp_r <= hp_high;
          end
        end
        hp_high: begin
          transfer_ack_oe <= 1'b0;
          hp_r <= hp_idle;
        end
        default: begin
          hp_r <= hp_idle;
        end
      endcase
    end
  end
endmodule

// ### logic/tsi_pkg.sv
// Constants and types shared by the switch control logic
package tsi_pkg;
  // Stream geometry
  localparam int STREAMS = 32;
  localparam int CH_PER_FRAME = 512;
  localparam int STREAM_W = 5;
  localparam int CH_W = 9;
  localparam int SLOT_W = 14;
  localparam int BIT_CNT_W = 12;
  localparam int OEI_FIRST = 16;
  localparam int OFFSET_W = 3;
  localparam int DLY_TAPS = 8;
  localparam int DMEM_WORDS = 2 * STREAMS * CH_PER_FRAME;
  localparam int CMEM_WORDS = STREAMS * CH_PER_FRAME;

  // Timing figures
  localparam int MCLK_PERIOD_NS = 25;
  localparam int RESET_MIN_NS = 20;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int BIT_CLK_KHZ = 32768;
  localparam int FRAME_US = 125;

  // Host address map
  localparam logic [1:0] SEL_CMEM = 2'h0;
  localparam logic [1:0] SEL_DMEM = 2'h1;
  localparam logic [15:0] REG_CTRL = 16'h8000;
  localparam logic [15:0] REG_STATUS = 16'h8001;
  localparam logic [15:0] REG_DELAY = 16'h8002;
  localparam logic [15:0] REG_OFFS_BASE = 16'h8020;

  // Control and status fields
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int CTRL_OEI_BIT = 1;
  localparam int STATUS_FMT_BIT = 0;
  localparam int MODE_HI = 15;
  localparam int MODE_LO = 14;

  // Reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [OFFSET_W-1:0] OFFS_RST = 3'h0;
  localparam logic IDLE_LVL_RST = 1'b1;

  // Per-channel modes
  localparam logic [1:0] MODE_VAR = 2'h0;
  localparam logic [1:0] MODE_CONST = 2'h1;
  localparam logic [1:0] MODE_PROC = 2'h2;
  localparam logic [1:0] MODE_HIZ = 2'h3;

  typedef enum logic [1:0] {hp_idle, hp_acc, hp_ack, hp_high} host_state_e;
endpackage

// ### verif/stream_partner.sv
// Stream side model: bit clock, frame pulse and input data
`timescale 1ns/1ps
module stream_partner (
  input wire logic mclk,
  input wire logic reset,
  output logic serial_bit_clock,
  output logic frame_sync_in,
  output logic delay_measure_input,
  output logic [tsi_pkg::STREAMS-1:0] serial_in_streams
);
  import tsi_pkg::*;
  logic [1:0] ph_r;
  logic [BIT_CNT_W-1:0] bit_r;
  always_ff @(negedge mclk) begin
    if (reset) begin
      ph_r <= 2'h0;
      bit_r <= '0;
    end else begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        bit_r <= bit_r + 1'b1;
      end
    end
  end
  assign serial_bit_clock = ph_r[1];
  assign frame_sync_in = reset || (bit_r != '0);
  assign serial_in_streams = {16{bit_r[1:0]}};
  // Evaluation pulse one bit time long, a fixed number of bits after frame start
  assign delay_measure_input = (bit_r == 12'h064);
endmodule

// ### verif/tsi_host_port_output_control_asserts.sv
// Port checks of the host port, acknowledge and output enables
`timescale 1ns/1ps
module tsi_host_port_output_control_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [tsi_pkg::STREAMS-1:0] serial_out_streams,
  input wire logic [tsi_pkg::STREAMS-1:0] serial_out_oe,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic host_data_oe,
  input wire logic transfer_ack,
  input wire logic transfer_ack_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  rst_float_a: assert property ($fell(reset) |-> !host_data_oe && !transfer_ack_oe
    && serial_out_oe == '0) else $error("outputs driven after reset");
  rst_zero_a: assert property ($fell(reset) |-> serial_out_streams == '0 && transfer_ack)
    else $error("output values not cleared by reset");
  ack_drive_a: assert property ($fell(transfer_ack) |-> transfer_ack_oe)
    else $error("acknowledge low while released");
  ack_high_a: assert property ($rose(transfer_ack) |-> transfer_ack_oe)
    else $error("acknowledge not driven high at cycle end");
  ack_release_a: assert property ($fell(transfer_ack_oe) |-> transfer_ack && $past(transfer_ack))
    else $error("acknowledge released without high drive");
  rd_drive_a: assert property (host_data_oe |-> transfer_ack_oe && !transfer_ack)
    else $error("data bus driven outside an access");
  idle_float_a: assert property ((chip_select_n || data_strobe_n) [*6] |->
    !host_data_oe && transfer_ack) else $error("port active while deselected");
  wr_float_a: assert property ((!read_write) [*6] |-> !host_data_oe)
    else $error("data bus driven during write");
  ack_time_a: assert property ((!chip_select_n && !data_strobe_n) [*8] |-> !transfer_ack)
    else $error("access not acknowledged in time");
endmodule
bind tsi_host_port_output_control tsi_host_port_output_control_asserts
  tsi_host_port_output_control_asserts_i (.mclk(mclk), .reset(reset),
  .serial_out_streams(serial_out_streams), .serial_out_oe(serial_out_oe),
  .chip_select_n(chip_select_n), .data_strobe_n(data_strobe_n), .read_write(read_write),
  .host_data_oe(host_data_oe), .transfer_ack(transfer_ack),
  .transfer_ack_oe(transfer_ack_oe));

// ### verif/tsi_host_port_output_control_test.sv
// Self-checking bench for the host port and output control
`timescale 1ns/1ps
module tsi_host_port_output_control_test;
  import tsi_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic master_output_enable = 1'b0;
  logic serial_bit_clock, frame_sync_in, host_data_oe, transfer_ack, transfer_ack_oe;
  logic delay_measure_input;
  logic [STREAMS-1:0] serial_in_streams, serial_out_streams, serial_out_oe;
  logic chip_select_n = 1'b1;
  logic data_strobe_n = 1'b1;
  logic read_write = 1'b1;
  logic [15:0] host_address = 16'h0000;
  logic [15:0] host_data_in = 16'h0000;
  logic [15:0] host_data_out, rd;
  int err_count = 0;
  int n_tests = 0;
  int cnt;
  int ones;
  int ind;
  always #12.5 mclk = ~mclk;
  tsi_host_port_output_control tsi_host_port_output_control_i (.mclk, .reset,
    .serial_bit_clock, .frame_sync_in, .delay_measure_input, .master_output_enable,
    .serial_in_streams, .serial_out_streams, .serial_out_oe, .chip_select_n, .data_strobe_n,
    .read_write, .host_address, .host_data_in, .host_data_out, .host_data_oe,
    .transfer_ack, .transfer_ack_oe);
  stream_partner stream_partner_i (.mclk, .reset, .serial_bit_clock, .frame_sync_in,
    .delay_measure_input, .serial_in_streams);
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One host access, held until acknowledged, then a quiet gap
  task host_acc(input logic rw, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] q);
    int i;
    @(negedge mclk);
    chip_select_n = 1'b0;
    data_strobe_n = 1'b0;
    read_write = rw;
    host_address = a;
    host_data_in = d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (!(transfer_ack === 1'b0 && host_data_oe === rw) && i < 20);
    q = host_data_out;
    chk("ack timeout", {31'h0, i >= 20}, 32'h0);
    @(negedge mclk);
    chip_select_n = 1'b1;
    data_strobe_n = 1'b1;
    repeat (10) @(negedge mclk);
  endtask
  // Frame-long counts on stream 0 (float, driven ones) and on the first indication pin
  task count_float;
    cnt = 0;
    ones = 0;
    ind = 0;
    repeat (CH_PER_FRAME * 8 * 4) begin
      @(posedge mclk);
      if (serial_out_oe[0] === 1'b0) begin
        cnt++;
      end
      if (serial_out_oe[0] === 1'b1 && serial_out_streams[0] === 1'b1) begin
        ones++;
      end
      if (serial_out_oe[OEI_FIRST] === 1'b1 && serial_out_streams[OEI_FIRST] === 1'b0) begin
        ind++;
      end
    end
  endtask
  initial begin
    #(25 * 90000);
    err_count++;
    end_sim();
  end
  initial begin
    logic [2:0] cfg [3];
    int exp [3];
    int eon [3];
    cfg = '{3'b000, 3'b100, 3'b011};
    exp = '{CH_PER_FRAME * 32, 32, 32};
    eon = '{0, (CH_PER_FRAME - 1) * 16, (CH_PER_FRAME - 1) * 16};
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    host_acc(1'b1, REG_STATUS, 16'h0000, rd);
    chk("status", rd, 32'h0);
    host_acc(1'b0, REG_STATUS, 16'hFFFF, rd);
    host_acc(1'b1, REG_STATUS, 16'h0000, rd);
    chk("status write", rd, 32'h0);
    host_acc(1'b1, 16'h9000, 16'h0000, rd);
    chk("unmapped", rd, 32'h0);
    host_acc(1'b0, REG_CTRL, 16'h0001, rd);
    host_acc(1'b1, REG_CTRL, 16'h0000, rd);
    chk("ctrl", rd, 32'h1);
    for (int c = 0; c < CH_PER_FRAME; c++) begin
      host_acc(1'b0, 16'(c), (c == 3) ? {MODE_HIZ, 14'h0000} : {MODE_PROC, 14'h00A5}, rd);
    end
    host_acc(1'b1, 16'h0003, 16'h0000, rd);
    chk("cmem", rd, {16'h0, MODE_HIZ, 14'h0000});
    cnt = 0;
    while (frame_sync_in !== 1'b0 && cnt < 20000) begin
      @(negedge mclk);
      cnt++;
    end
    repeat (1000) @(negedge mclk);
    host_acc(1'b1, REG_DELAY, 16'h0000, rd);
    chk("delay", rd, 32'h63);
    for (int k = 0; k < 3; k++) begin
      @(negedge mclk);
      master_output_enable = cfg[k][2];
      host_acc(1'b0, REG_CTRL, {14'h0000, cfg[k][1:0]}, rd);
      count_float();
      chk("float cycles", 32'(cnt), 32'(exp[k]));
      chk("ones on stream 0", 32'(ones), 32'(eon[k]));
      if (cfg[k][1]) begin
        chk("indication", 32'(ind), 32'h20);
      end
    end
    end_sim();
  end
endmodule
